// ===== src/lhp_host_port.v
// Host port access logic: parallel and serial host links, bus holder, RAM addressing
//
// Function
// - RS high reads/writes display RAM data; RS low reads status or writes a command.
// - Serial bits and clock accepted only while both chip selects are active.
// - Serial bits sampled on rising serial clock, bit seven first.
// - Eighth rising serial clock edge turns the shifted bits into one byte.
// - RS is sampled on every eighth serial edge: low command, high data.
// - Deselect in serial mode clears the shift register and bit counter.
// - Serial mode never reads back data or status.
// - Without both selects active the data bus floats and strobes are ignored.
// - A data read drives the old holder content, then reloads the holder.
// - Written data goes into the holder and into RAM before the next write.
// - Status bit seven is busy; while busy only status reads are accepted.
// - RAM is 65 rows by 132 columns, addressed by page and column.
// - Page changes only by the page set command, never automatically.
// - Page 8 has one row; only bit zero is meaningful.
// - Column advances by one after each display data read or write.
// - Column stops at 83h and never carries into the page.
// - Segment direction 0 maps column 0 first; 1 reverses the mapping.
// - Start line chooses which RAM line drives the top common row.
// - Display spans 65 lines from the start line; changing it scrolls.
// - Host RAM access path is independent of display refresh readout.
// - Interface strap high selects parallel bus, low selects serial link.
// - Bus style strap high: enable plus read/write; low: separate strobes.
`timescale 1ns/1ps
`default_nettype none
`include "lhp_consts.vh"

module lhp_host_port #(
  parameter AW = `LHP_ADDR_W
) (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       if_parallel,
  input  wire       bus_style_select,
  input  wire       chip_select_low_active_b,
  input  wire       chip_select_high_active,
  input  wire       register_select,
  input  wire       rd_strobe,
  input  wire       wr_strobe,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_b,
  input  wire       serial_data,
  input  wire       serial_clk,
  input  wire       busy,
  output reg  [7:0] cmd_byte,
  output reg        cmd_valid,
  output reg  [3:0] page_addr,
  output reg  [7:0] col_addr,
  output reg  [5:0] start_line,
  output reg        seg_reverse,
  input  wire [6:0] disp_row,
  input  wire [7:0] disp_seg,
  output reg        disp_pixel
);

  // ----------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------------
  reg        rst_m_q;
  reg        rst_s_q;
  wire       rst_n = rst_s_q;

  // Release through two flops so every flop leaves reset on the same edge
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  localparam PW = 17;
  wire [PW-1:0] pins = {if_parallel, bus_style_select, chip_select_low_active_b,
                        chip_select_high_active, register_select, rd_strobe,
                        wr_strobe, serial_data, serial_clk, data_in};
  reg  [PW-1:0] meta_q;
  reg  [PW-1:0] sync_q;
  reg  [PW-1:0] prev_q;

  // Deselected idle levels keep the edge detectors quiet after reset
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= `LHP_RST_PINS;
      sync_q <= `LHP_RST_PINS;
      prev_q <= `LHP_RST_PINS;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire       par_s   = sync_q[16];
  wire       style_s = sync_q[15];
  wire       sel_s   = ~sync_q[14] & sync_q[13];
  wire       sel_p   = ~prev_q[14] & prev_q[13];
  wire       rs_s    = sync_q[12];
  wire       rs_p    = prev_q[12];
  wire       rd_s    = sync_q[11];
  wire       rd_p    = prev_q[11];
  wire       wr_s    = sync_q[10];
  wire       wr_p    = prev_q[10];
  wire       sdi_s   = sync_q[9];
  wire       sck_s   = sync_q[8];
  wire       sck_p   = prev_q[8];
  wire [7:0] dat_p   = prev_q[7:0];

  // ----------------------------------------------------------------------------
  // Parallel strobe decode
  // ----------------------------------------------------------------------------
  // Enable style: rd_strobe is enable, wr_strobe is read/not-write
  wire rd_act = par_s & sel_s & (style_s ? (rd_s & wr_s) : ~rd_s);
  wire par_wr = par_s & sel_p & (style_s ? (rd_p & ~rd_s & ~wr_p)
                                         : (~wr_p & wr_s));
  reg  rd_act_q;
  reg  rd_data_q;

  // ----------------------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------------------
  reg  [6:0] sh_q;
  reg  [2:0] bit_q;
  wire       ser_act = ~par_s & sel_s;
  wire       sck_up  = ser_act & sck_s & ~sck_p;
  wire       ser_wr  = sck_up & (bit_q == `LHP_SER_BITS);

  // Shift MSB first; deselect returns everything to its start state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_q  <= 7'h00;
      bit_q <= 3'h0;
    end else if (!ser_act) begin
      sh_q  <= 7'h00;
      bit_q <= 3'h0;
    end else if (sck_up) begin
      sh_q  <= {sh_q[5:0], sdi_s};
      bit_q <= bit_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Common write event from either link
  // ----------------------------------------------------------------------------
  wire       wev   = (par_wr | ser_wr) & ~busy;
  wire [7:0] wbyte = par_wr ? dat_p : {sh_q, sdi_s};
  wire       wrs   = par_wr ? rs_p : rs_s;
  wire       ram_ok = (page_addr <= `LHP_PAGE_LAST) & (col_addr <= `LHP_COL_LAST);

  // ----------------------------------------------------------------------------
  // RAM addressing
  // ----------------------------------------------------------------------------
  wire [AW-1:0] host_addr = {page_addr, 7'h00} + {5'h00, page_addr, 2'h0}
                          + {3'h0, col_addr};
  wire [7:0]    host_rdata;
  wire [7:0]    page8_mask = (page_addr == `LHP_PAGE_LAST) ? 8'h01 : 8'hff;
  wire          ram_we = wev & wrs & ram_ok;
  reg  [7:0]    holder_q;

  // ----------------------------------------------------------------------------
  // Host side state: holder, addresses, commands
  // ----------------------------------------------------------------------------
  wire rd_start = rd_act & ~rd_act_q;
  wire rd_end   = ~rd_act & rd_act_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_q    <= 1'b0;
      rd_data_q   <= 1'b0;
      holder_q    <= 8'h00;
      data_out    <= 8'h00;
      data_oe_b   <= 1'b1;
      cmd_byte    <= 8'h00;
      cmd_valid   <= 1'b0;
      page_addr   <= `LHP_RST_PAGE;
      col_addr    <= `LHP_RST_COL;
      start_line  <= `LHP_RST_START;
      seg_reverse <= `LHP_RST_SEGREV;
    end else begin
      rd_act_q  <= rd_act;
      cmd_valid <= 1'b0;
      // Bus floats unless a selected parallel read is in progress
      data_oe_b <= ~rd_act;
      if (rd_start) begin
        rd_data_q <= register_select_ok(rs_s);
        if (rs_s) begin
          data_out <= holder_q & page8_mask;
        end else begin
          data_out <= 8'h00;
          data_out[`LHP_STAT_BUSY]   <= busy;
          data_out[`LHP_STAT_SEGREV] <= seg_reverse;
        end
      end
      // Reload the holder only after the old content was presented
      // Off-map columns leave the holder and the column alone
      if (rd_end && rd_data_q && !busy && ram_ok) begin
        holder_q <= host_rdata & page8_mask;
        if (col_addr < `LHP_COL_LAST) begin
          col_addr <= col_addr + 8'h01;
        end
      end
      if (wev) begin
        if (wrs) begin
          holder_q <= wbyte & page8_mask;
          if (col_addr < `LHP_COL_LAST) begin
            col_addr <= col_addr + 8'h01;
          end
        end else begin
          cmd_byte  <= wbyte;
          cmd_valid <= 1'b1;
          if (wbyte[7:4] == `LHP_CMD_PAGE) begin
            if (wbyte[3:0] <= `LHP_PAGE_LAST) begin
              page_addr <= wbyte[3:0];
            end
          end else if (wbyte[7:4] == `LHP_CMD_COL_HI) begin
            col_addr[7:4] <= wbyte[3:0];
          end else if (wbyte[7:4] == `LHP_CMD_COL_LO) begin
            col_addr[3:0] <= wbyte[3:0];
          end else if (wbyte[7:6] == `LHP_CMD_START) begin
            start_line <= wbyte[5:0];
          end else if (wbyte[7:1] == `LHP_CMD_SEGDIR) begin
            seg_reverse <= wbyte[0];
          end
        end
      end
    end
  end

  // Of the reads, only a data read reloads the holder and moves the column
  function register_select_ok;
    input rs;
    begin
      register_select_ok = rs;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Display refresh readout
  // ----------------------------------------------------------------------------
  reg  [6:0]    line_c;
  reg  [7:0]    dcol_c;
  reg  [2:0]    bit_sel_q;
  wire [6:0]    line_sum = {1'b0, start_line} + disp_row;
  wire [AW-1:0] disp_addr = {line_c[6:3], 7'h00} + {5'h00, line_c[6:3], 2'h0}
                          + {3'h0, dcol_c};
  wire [7:0]    disp_byte;

  // Wrap the 65-line window and apply segment direction
  always @* begin
    if (line_sum >= 7'd65) begin
      line_c = line_sum - 7'd65;
    end else begin
      line_c = line_sum;
    end
    if (seg_reverse) begin
      dcol_c = `LHP_COL_LAST - disp_seg;
    end else begin
      dcol_c = disp_seg;
    end
  end

  // Bit select lags one cycle to match the RAM read latency
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bit_sel_q  <= 3'h0;
      disp_pixel <= 1'b0;
    end else begin
      bit_sel_q  <= line_c[2:0];
      disp_pixel <= disp_byte[bit_sel_q];
    end
  end

  // ----------------------------------------------------------------------------
  // Display RAM with separate host and refresh read ports
  // ----------------------------------------------------------------------------
  lhp_disp_ram #(
    .DEPTH (`LHP_RAM_DEPTH),
    .AW    (AW)
  ) u_ram (
    .clk_sys   (clk_sys),
    .wr_en     (ram_we),
    .wr_addr   (host_addr),
    .wr_data   (wbyte & page8_mask),
    .host_addr (host_addr),
    .host_data (host_rdata),
    .disp_addr (disp_addr),
    .disp_data (disp_byte)
  );

endmodule
`default_nettype wire

// ===== src/lhp_consts.vh
// Constants shared by the host-port access logic and its display RAM
`ifndef LHP_CONSTS_VH
`define LHP_CONSTS_VH

// ----------------------------------------------------------------------------
// Display RAM geometry
// ----------------------------------------------------------------------------
`define LHP_COLS          132
`define LHP_PAGES         9
`define LHP_LINES         65
`define LHP_RAM_DEPTH     1188
`define LHP_ADDR_W        11
`define LHP_COL_LAST      8'h83
`define LHP_PAGE_LAST     4'h8

// ----------------------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------------------
`define LHP_STAT_BUSY     7
`define LHP_STAT_SEGREV   6

// ----------------------------------------------------------------------------
// Command codes (upper bits matched, lower bits carry the argument)
// ----------------------------------------------------------------------------
`define LHP_CMD_PAGE      4'hb
`define LHP_CMD_COL_HI    4'h1
`define LHP_CMD_COL_LO    4'h0
`define LHP_CMD_START     2'h1
`define LHP_CMD_SEGDIR    7'h50

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LHP_RST_PAGE      4'h0
`define LHP_RST_COL       8'h00
`define LHP_RST_START     6'h00
`define LHP_RST_SEGREV    1'b0
// Pin history idle image: active-low select, read and write strobes high
`define LHP_RST_PINS      17'h04c00

// ----------------------------------------------------------------------------
// Serial link timing
// ----------------------------------------------------------------------------
`define LHP_SER_BITS      3'h7

`endif

// ===== src/lhp_disp_ram.v
// Display RAM with one write port and two independent read ports
`timescale 1ns/1ps
`default_nettype none
`include "lhp_consts.vh"

module lhp_disp_ram #(
  parameter DEPTH = `LHP_RAM_DEPTH,
  parameter AW    = `LHP_ADDR_W
) (
  input  wire          clk_sys,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] host_addr,
  output reg  [7:0]    host_data,
  input  wire [AW-1:0] disp_addr,
  output reg  [7:0]    disp_data
);

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  reg [7:0] mem [0:DEPTH-1];

  // Separate refresh port, so host traffic never stalls the panel readout
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    host_data <= mem[host_addr];
    disp_data <= mem[disp_addr];
  end

endmodule
`default_nettype wire

// ===== test/lhp_host_port_properties.sv
// Concurrent checks bound to the host port access logic
`timescale 1ns/1ps
`default_nettype none

module lhp_host_port_props (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       if_parallel,
  input wire logic       chip_select_low_active_b,
  input wire logic       chip_select_high_active,
  input wire logic       data_oe_b,
  input wire logic       busy,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_valid,
  input wire logic [3:0] page_addr,
  input wire logic [7:0] col_addr,
  input wire logic [5:0] start_line,
  input wire logic       seg_reverse
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // One domain; the raw reset masks the checks, but not the synchroniser's release
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  bus_float_a:
    assert property ((chip_select_low_active_b || !chip_select_high_active)[*6] |-> data_oe_b)
    else $error("Data bus driven while deselected");
  serial_quiet_a:
    assert property ((!if_parallel)[*6] |-> data_oe_b)
    else $error("Data bus driven in serial mode");
  col_step_a:
    assert property ($changed(col_addr) && !cmd_valid && !$past(cmd_valid) && !$past(cmd_valid, 2)
      |-> col_addr == $past(col_addr) + 8'h01)
    else $error("Column moved by other than one");
  col_cap_a:
    assert property ($changed(col_addr) && !$past(cmd_valid) |-> col_addr <= 8'h83 || cmd_valid)
    else $error("Column ran past the last column");
  page_hold_a:
    assert property ($changed(page_addr) |-> (cmd_valid || $past(cmd_valid)) or ##1 cmd_valid)
    else $error("Page changed without a command");
  page_range_a:
    assert property (page_addr <= 4'h8)
    else $error("Page beyond the last page");
  cmd_pulse_a:
    assert property (cmd_valid |=> !cmd_valid)
    else $error("Command strobe longer than one cycle");
  seg_dir_a:
    assert property (cmd_valid && cmd_byte == 8'ha1 |-> ##[0:1] seg_reverse)
    else $error("Segment reversal not taken");
  start_set_a:
    assert property (cmd_valid && cmd_byte[7:6] == 2'b01 |-> ##[0:1] start_line == cmd_byte[5:0])
    else $error("Start line not taken");
  busy_hold_a:
    assert property (busy[*8] |-> $stable(col_addr) && $stable(page_addr))
    else $error("Address moved while busy");
endmodule

bind lhp_host_port lhp_host_port_props u_props (.*);
`default_nettype wire

// ===== test/lhp_host_model.sv
// Host processor model on the parallel bus and the serial link
`timescale 1ns/1ps
`default_nettype none

module lhp_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_b,
  output var  logic       if_parallel,
  output var  logic       bus_style_select,
  output var  logic       chip_select_low_active_b,
  output var  logic       chip_select_high_active,
  output var  logic       register_select,
  output var  logic       rd_strobe,
  output var  logic       wr_strobe,
  output var  logic [7:0] data_in,
  output var  logic       serial_data,
  output var  logic       serial_clk
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Parallel, separate strobes, selected, everything idle
  initial begin
    {if_parallel, bus_style_select} = 2'b10;
    {chip_select_low_active_b, chip_select_high_active} = 2'b01;
    {register_select, rd_strobe, wr_strobe} = 3'b011;
    data_in = 8'h00;
    {serial_data, serial_clk} = 2'b00;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic sel(input logic lo_b, input logic hi);
    @(negedge clk_sys);
    chip_select_low_active_b = lo_b;
    chip_select_high_active = hi;
    wait_n(4);
  endtask

  // Straps only move while deselected, so a style change is no strobe
  task automatic set_mode(input logic par, input logic sty);
    sel(1'b0, 1'b0);
    if_parallel = par;
    bus_style_select = sty;
    rd_strobe = !sty;
    wr_strobe = 1'b1;
    sel(1'b0, 1'b1);
  endtask

  // One bus cycle; strobe held 12 clocks, well past the answer time
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    register_select = rs;
    data_in = rw ? ~data_in : d;
    if (bus_style_select) wr_strobe = rw;
    wait_n(4);
    if (bus_style_select) rd_strobe = 1'b1;
    else if (rw) rd_strobe = 1'b0;
    else wr_strobe = 1'b0;
    wait_n(12);
    // A released bus reads back inverted, so a missing drive shows up
    q = data_oe_b ? ~data_out : data_out;
    rd_strobe = !bus_style_select;
    if (!bus_style_select) wr_strobe = 1'b1;
    wait_n(6);
    wr_strobe = 1'b1;
    data_in = ~data_in;
    wait_n(4);
  endtask

  // Serial clock stands low between frames; 125 ns period inside
  task automatic ser(input logic rs, input logic [7:0] d, input int n);
    @(negedge clk_sys);
    register_select = rs;
    for (int i = 7; i > 7 - n; i--) begin
      serial_data = d[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    serial_data = ~serial_data;
    wait_n(8);
  endtask
endmodule
`default_nettype wire

// ===== test/lhp_host_port_tb_top.sv
// Self-checking bench for the host port access logic
`timescale 1ns/1ps
`default_nettype none

module lhp_host_port_tb_top;
  logic            clk_sys, rst_b, busy;
  logic [6:0]      disp_row;
  logic [7:0]      disp_seg, q;
  wire logic       if_parallel, bus_style_select, chip_select_low_active_b;
  wire logic       chip_select_high_active, register_select, rd_strobe, wr_strobe;
  wire logic       serial_data, serial_clk, data_oe_b, cmd_valid, seg_reverse, disp_pixel;
  wire logic [7:0] data_in, data_out, cmd_byte, col_addr;
  wire logic [3:0] page_addr;
  wire logic [5:0] start_line;
  int              n_errors, cmp_count;

  lhp_host_port DUT (.*);
  lhp_host_model host (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    host.acc(1'b0, 1'b0, c, q);
  endtask

  task automatic wr(input logic rs, input logic [7:0] d);
    host.acc(rs, 1'b0, d, q);
  endtask

  task automatic rd(input logic rs);
    host.acc(rs, 1'b1, 8'h00, q);
  endtask

  // Pixel shows two clocks after the refresh position
  task automatic pix(input logic [6:0] r, input logic [7:0] s, input logic e);
    disp_row = r;
    disp_seg = s;
    repeat (3) @(negedge clk_sys);
    chk("pixel", {7'h00, e}, {7'h00, disp_pixel});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Commands back to back, no busy polling between them
  task automatic t_cmd;
    cmd(8'hb2);
    cmd(8'h11);
    cmd(8'h05);
    cmd(8'h43);
    cmd(8'hb9);
    chk("page", 8'h02, {4'h0, page_addr});
    chk("col", 8'h15, col_addr);
    chk("start", 8'h03, {2'b00, start_line});
    chk("cmd", 8'hb9, cmd_byte);
    $display("t_cmd done");
  endtask

  task automatic t_data;
    cmd(8'hb1);
    cmd(8'h18);
    cmd(8'h02);
    wr(1'b1, 8'h5a);
    wr(1'b1, 8'hc3);
    chk("col_sat", 8'h83, col_addr);
    chk("page_kept", 8'h01, {4'h0, page_addr});
    cmd(8'h02);
    rd(1'b1);
    rd(1'b1);
    chk("rd_first", 8'h5a, q);
    rd(1'b1);
    chk("rd_next", 8'hc3, q);
    busy = 1'b1;
    rd(1'b0);
    chk("stat_busy", 8'h80, q);
    cmd(8'h10);
    chk("busy_col", 8'h83, col_addr);
    busy = 1'b0;
    rd(1'b0);
    chk("stat_idle", 8'h00, q);
    $display("t_data done");
  endtask

  task automatic t_pg8;
    host.set_mode(1'b1, 1'b1);
    cmd(8'hb8);
    cmd(8'h10);
    cmd(8'h00);
    wr(1'b1, 8'hff);
    chk("wr_col", 8'h01, col_addr);
    cmd(8'h00);
    rd(1'b1);
    rd(1'b1);
    chk("pg8_bit0", 8'h01, q);
    $display("t_pg8 done");
  endtask

  // Bus left floating reads back as the inverse of the last driven byte
  task automatic t_desel;
    host.sel(1'b1, 1'b1);
    cmd(8'hb5);
    rd(1'b0);
    chk("desel_rd", 8'hfe, q);
    host.sel(1'b0, 1'b0);
    cmd(8'hb6);
    chk("desel_page", 8'h08, {4'h0, page_addr});
    chk("desel_bus", 8'h01, {7'h00, data_oe_b});
    host.sel(1'b0, 1'b1);
    $display("t_desel done");
  endtask

  task automatic t_ser;
    host.set_mode(1'b0, 1'b0);
    rd(1'b0);
    chk("ser_rd", 8'hfe, q);
    host.ser(1'b0, 8'hb3, 8);
    chk("ser_page", 8'h03, {4'h0, page_addr});
    host.ser(1'b0, 8'hff, 3);
    host.sel(1'b1, 1'b1);
    host.sel(1'b0, 1'b1);
    host.ser(1'b0, 8'h42, 8);
    chk("ser_flush", 8'h42, cmd_byte);
    host.sel(1'b0, 1'b0);
    host.ser(1'b0, 8'hb5, 8);
    host.sel(1'b0, 1'b1);
    chk("ser_desel", 8'h03, {4'h0, page_addr});
    host.ser(1'b0, 8'h10, 8);
    host.ser(1'b0, 8'h00, 8);
    host.ser(1'b1, 8'h81, 8);
    chk("ser_data", 8'h01, col_addr);
    chk("ser_bus", 8'h01, {7'h00, data_oe_b});
    host.set_mode(1'b1, 1'b0);
    $display("t_ser done");
  endtask

  task automatic t_pix;
    cmd(8'h40);
    pix(7'h09, 8'h82, 1'b1);
    pix(7'h08, 8'h82, 1'b0);
    cmd(8'h48);
    pix(7'h01, 8'h82, 1'b1);
    cmd(8'h7f);
    pix(7'h0b, 8'h82, 1'b1);
    cmd(8'ha1);
    pix(7'h0b, 8'h01, 1'b1);
    rd(1'b0);
    chk("stat_seg", 8'h40, q);
    cmd(8'ha0);
    pix(7'h0b, 8'h82, 1'b1);
    $display("t_pix done");
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset for five clocks, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    busy = 1'b0;
    disp_row = 7'h00;
    disp_seg = 8'h00;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (8) @(negedge clk_sys);
    t_cmd;
    t_data;
    t_pg8;
    t_desel;
    t_ser;
    t_pix;
    final_report;
  end

  // Tests need about 11 us; a hang stops well beyond that
  initial begin
    #200us;
    n_errors++;
    $display("Watchdog expired");
    final_report;
  end
endmodule
`default_nettype wire
